// ### rtl/motion_wake_pkg.sv
// Constants and types shared by the wake-on-motion controller
package motion_wake_pkg;
	localparam int mode_width = 2;
	localparam int thr_width = 8;
	localparam int accel_width = 8;
	localparam int pulse_width_cnt = 16;
	typedef enum logic [1:0]
	{
		mode_off = 2'h0,
		mode_rx_only = 2'h1,
		mode_host_only = 2'h2,
		mode_both = 2'h3
	} wake_mode_type;
	localparam logic [thr_width-1:0] thr_reset = 8'h00;
	localparam logic [thr_width-1:0] thr_default_code = 8'h00;
	// Threshold code for half a standard gravity on the linear 1..255 scale
	localparam logic [thr_width-1:0] thr_half_g = 8'h80;
	localparam logic [pulse_width_cnt-1:0] pulse_cycles_default = 16'h00c8;
	localparam logic [pulse_width_cnt-1:0] pulse_zero = 16'h0000;
	localparam logic [pulse_width_cnt-1:0] pulse_one = 16'h0001;
endpackage

// ### rtl/motion_wake_if.sv
// Synchronised sensor event passing into the pulse generator
`timescale 1ns/1ps
interface motion_wake_if;
	logic pulse_req;
	logic pulse_active;
	modport source
	(
		output pulse_req,
		input pulse_active
	);
	modport sink
	(
		input pulse_req,
		output pulse_active
	);
endinterface // motion_wake_if

// ### rtl/motion_pulse_gen.sv
// Fixed-width pulse generator for the motion wake pin
`timescale 1ns/1ps
module motion_pulse_gen
	import motion_wake_pkg::*;
#(
	parameter logic [pulse_width_cnt-1:0] pulse_cycles = pulse_cycles_default
)
(
	input wire logic mclk,
	input wire logic srst,
	motion_wake_if.sink evt
);
	logic [pulse_width_cnt-1:0] cnt_ff;
	logic [pulse_width_cnt-1:0] nxt_cnt;
	// Reload on request, otherwise count down to idle
	assign nxt_cnt = evt.pulse_req ? pulse_cycles :
		(cnt_ff != pulse_zero) ? cnt_ff - pulse_one : pulse_zero; // [RULE14]
	assign evt.pulse_active = (cnt_ff != pulse_zero);
	// Counter register
	always_ff @(posedge mclk)
	begin
		if (srst)
			cnt_ff <= pulse_zero;
		else
			cnt_ff <= nxt_cnt;
	end
endmodule // motion_pulse_gen

// ### rtl/motion_wake_ctrl.sv
// Wake-on-motion controller top level
// Overview of operation
// RULE1: Mode resets to 0; mode 0 never wakes receiver nor drives the pin.
// RULE2: Mode 1 wakes receiver on sensor interrupt, leaves the wake pin quiet.
// RULE3: Mode 2 pulses the wake pin on motion, receiver stays asleep.
// RULE4: Mode 3 wakes receiver and pulses the wake pin.
// RULE5: A woken receiver stays in normal operation, not back to backup.
// RULE6: Threshold codes 1..255 map linearly from zero to one gravity.
// RULE7: Threshold resets to 0, treated as half a gravity.
// RULE8: One threshold for all axes; any axis above it raises motion.
// RULE9: Host commits settings and power cycles the receiver after changes.
// RULE10: Host enters backup through a power request with zero duration.
// RULE11: Host keeps the external interrupt zero wake source enabled.
// RULE12: Power cycle needed only after the motion configuration changes.
// RULE13: Receiver wake acts only while the receiver is in backup mode.
// RULE14: Sensor interrupt synchronised; wake pin pulses have fixed width.
`timescale 1ns/1ps
module motion_wake_ctrl
	import motion_wake_pkg::*;
#(
	parameter logic [pulse_width_cnt-1:0] pulse_cycles = pulse_cycles_default
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [motion_wake_pkg::mode_width-1:0] motion_wake_mode_setting,
	input wire logic [motion_wake_pkg::thr_width-1:0] motion_wake_threshold_setting,
	input wire logic cfg_load,
	input wire logic [motion_wake_pkg::accel_width-1:0] accel_x,
	input wire logic [motion_wake_pkg::accel_width-1:0] accel_y,
	input wire logic [motion_wake_pkg::accel_width-1:0] accel_z,
	input wire logic accel_valid,
	input wire logic sensor_irq,
	input wire logic backup_mode,
	input wire logic external_irq_zero_wake_source,
	output logic motion_wake_pin,
	output logic rx_wake,
	output logic sensor_irq_out,
	output logic [motion_wake_pkg::thr_width-1:0] active_threshold
);
	import motion_wake_pkg::*;

	// ************************************************************
	// Configuration
	// ************************************************************
	wake_mode_type mode_ff;
	logic [thr_width-1:0] thr_ff;
	logic [thr_width-1:0] eff_thr;
	// Settings latch on load and take effect from the next clock cycle
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mode_ff <= mode_off; // [RULE1]
			thr_ff <= thr_reset; // [RULE7]
		end
		else if (cfg_load)
		begin
			mode_ff <= wake_mode_type'(motion_wake_mode_setting); // [RULE9]
			thr_ff <= motion_wake_threshold_setting;
		end
	end
	// Code 0 is replaced by the half-gravity code
	assign eff_thr = (thr_ff == thr_default_code) ? thr_half_g : thr_ff; // [RULE7] [RULE6]
	logic [thr_width-1:0] act_thr_ff;
	// Effective threshold registered so the output comes from a flop
	always_ff @(posedge mclk)
	begin
		if (srst)
			act_thr_ff <= thr_half_g; // [RULE7]
		else
			act_thr_ff <= eff_thr;
	end

	// ************************************************************
	// Motion detection in the sensor
	// ************************************************************
	logic any_axis_over;
	logic irq_out_ff;
	logic nxt_irq_out;
	localparam int axis_count = 3;
	logic [accel_width-1:0] axis_val [axis_count];
	logic [axis_count-1:0] axis_over;
	// Axis samples use the same linear code scale as the threshold
	assign axis_val[0] = accel_x;
	assign axis_val[1] = accel_y;
	assign axis_val[2] = accel_z;
	// One comparator per axis against the shared threshold
	for (genvar g = 0; g < axis_count; g++)
	begin : g_axis
		assign axis_over[g] = (axis_val[g] > eff_thr); // [RULE8] [RULE6]
	end
	assign any_axis_over = |axis_over; // [RULE8]
	assign nxt_irq_out = accel_valid && any_axis_over && (mode_ff != mode_off);
	// Interrupt line driven towards the sensor pin
	always_ff @(posedge mclk)
	begin
		if (srst)
			irq_out_ff <= 1'b0;
		else
			irq_out_ff <= nxt_irq_out; // [RULE8]
	end

	// ************************************************************
	// Interrupt synchroniser and edge detect
	// ************************************************************
	logic irq_s1_ff;
	logic irq_s2_ff;
	logic irq_s3_ff;
	logic irq_rise;
	// Two-stage synchroniser plus one history stage
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			irq_s1_ff <= 1'b0;
			irq_s2_ff <= 1'b0;
			irq_s3_ff <= 1'b0;
		end
		else
		begin
			irq_s1_ff <= sensor_irq; // [RULE14]
			irq_s2_ff <= irq_s1_ff;
			irq_s3_ff <= irq_s2_ff;
		end
	end
	assign irq_rise = irq_s2_ff && !irq_s3_ff;

	// ************************************************************
	// Mode decode
	// ************************************************************
	logic mode_wakes_rx;
	logic mode_drives_pin;
	logic backup_s1_ff;
	logic backup_s2_ff;
	// Backup state arrives from the power logic's own domain
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			backup_s1_ff <= 1'b0;
			backup_s2_ff <= 1'b0;
		end
		else
		begin
			backup_s1_ff <= backup_mode;
			backup_s2_ff <= backup_s1_ff;
		end
	end
	assign mode_wakes_rx = (mode_ff == mode_rx_only) || (mode_ff == mode_both); // [RULE2] [RULE4]
	assign mode_drives_pin = (mode_ff == mode_host_only) || (mode_ff == mode_both); // [RULE3] [RULE4]

	// ************************************************************
	// Receiver wake
	// ************************************************************
	logic src_s1_ff;
	logic src_s2_ff;
	logic wake_ff;
	logic nxt_wake;
	// Wake source enable is a host level from outside
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			src_s1_ff <= 1'b0;
			src_s2_ff <= 1'b0;
		end
		else
		begin
			src_s1_ff <= external_irq_zero_wake_source;
			src_s2_ff <= src_s1_ff; // [RULE11]
		end
	end
	// Wake holds until backup ends, then normal operation follows
	assign nxt_wake = backup_s2_ff && (wake_ff ||
		(irq_rise && mode_wakes_rx && src_s2_ff)); // [RULE13] [RULE5]
	always_ff @(posedge mclk)
	begin
		if (srst)
			wake_ff <= 1'b0;
		else
			wake_ff <= nxt_wake; // [RULE2]
	end

	// ************************************************************
	// Host wake pin
	// ************************************************************
	motion_wake_if evt ();
	logic pin_ff;
	assign evt.pulse_req = irq_rise && mode_drives_pin; // [RULE3]
	motion_pulse_gen #(
		.pulse_cycles(pulse_cycles)
	) u_pulse (
		.mclk(mclk),
		.srst(srst),
		.evt(evt)
	);
	// Registered pin, cleared when mode stops driving it
	always_ff @(posedge mclk)
	begin
		if (srst)
			pin_ff <= 1'b0;
		else
			pin_ff <= evt.pulse_active && mode_drives_pin; // [RULE1] [RULE14]
	end

	assign motion_wake_pin = pin_ff;
	assign rx_wake = wake_ff;
	assign sensor_irq_out = irq_out_ff;
	assign active_threshold = act_thr_ff;

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_rise_in_mode(logic m);
		irq_rise && m;
	endsequence
	property p_off_quiet;
		@(posedge mclk) disable iff (srst) (mode_ff == mode_off) |=> !motion_wake_pin && !rx_wake;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("mode 0 drove a wake"); // [RULE1]
	property p_mode1_pin;
		@(posedge mclk) disable iff (srst) (mode_ff == mode_rx_only) |=> !motion_wake_pin;
	endproperty
	a_mode1_pin: assert property (p_mode1_pin) else $error("mode 1 drove pin"); // [RULE2]
	property p_pin_pulse;
		@(posedge mclk) disable iff (srst)
		s_rise_in_mode(mode_drives_pin) ##1 mode_drives_pin |=> motion_wake_pin;
	endproperty
	a_pin_pulse: assert property (p_pin_pulse) else $error("no pin pulse"); // [RULE3]
	property p_mode2_norx;
		@(posedge mclk) disable iff (srst) (mode_ff == mode_host_only) && !wake_ff |=> !rx_wake;
	endproperty
	a_mode2_norx: assert property (p_mode2_norx) else $error("mode 2 woke rx"); // [RULE3]
	property p_rx_wake;
		@(posedge mclk) disable iff (srst)
		s_rise_in_mode(mode_wakes_rx && backup_s2_ff && src_s2_ff) |=> rx_wake;
	endproperty
	a_rx_wake: assert property (p_rx_wake) else $error("rx not woken"); // [RULE4]
	property p_wake_hold;
		@(posedge mclk) disable iff (srst) rx_wake && backup_s2_ff |=> rx_wake;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake dropped"); // [RULE5]
	property p_zero_thr;
		@(posedge mclk) disable iff (srst)
		(thr_ff == thr_default_code) |=> active_threshold == thr_half_g;
	endproperty
	a_zero_thr: assert property (p_zero_thr) else $error("zero threshold wrong"); // [RULE7]
	property p_axis;
		@(posedge mclk) disable iff (srst)
		accel_valid && (mode_ff != mode_off) && (accel_y > eff_thr) |=> sensor_irq_out;
	endproperty
	a_axis: assert property (p_axis) else $error("axis over threshold missed"); // [RULE8]
	property p_backup_only;
		@(posedge mclk) disable iff (srst) !backup_s2_ff |=> !rx_wake;
	endproperty
	a_backup_only: assert property (p_backup_only) else $error("wake outside backup"); // [RULE13]
	property p_sync;
		@(posedge mclk) disable iff (srst) $rose(irq_s2_ff) |-> $past(irq_s1_ff);
	endproperty
	a_sync: assert property (p_sync) else $error("synchroniser broken"); // [RULE14]
endmodule // motion_wake_ctrl

// ### tb/wake_pin_host.sv
// Host model that watches the motion wake pin
`timescale 1ns/1ps
module wake_pin_host
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic motion_wake_pin,
	output logic [7:0] pulse_count,
	output logic [7:0] last_width
)
;
	// ****************
	// Pulse counting
	// ****************
	logic [7:0] run_ff;
	// Counts pulses and keeps the width of the last one
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			run_ff <= 8'h00;
			pulse_count <= 8'h00;
			last_width <= 8'h00;
		end
		else
		begin
			run_ff <= motion_wake_pin ? run_ff + 8'h01 : 8'h00;
			if (!motion_wake_pin && run_ff != 8'h00)
			begin
				pulse_count <= pulse_count + 8'h01;
				last_width <= run_ff;
			end
		end
	end
endmodule // wake_pin_host

// ### tb/motion_wake_ctrl_test.sv
// Self-checking bench for the wake-on-motion controller
`timescale 1ns/1ps
module motion_wake_ctrl_test;
	import motion_wake_pkg::*;
	// ****************
	// Bench
	// ****************
	localparam logic [15:0] pw = 16'h0004;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic cfg_load = 1'b0;
	logic accel_valid = 1'b0;
	logic sensor_irq = 1'b0;
	logic backup_mode = 1'b0;
	logic wake_src = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [7:0] thr = 8'h00, ax = 8'h00, ay = 8'h00, az = 8'h00, t, n0;
	logic pin, rx_wake, irq_out;
	logic [7:0] act_thr, n_pulse, width;
	int num_errors = 0;
	int checked = 0;
	int seed = 91;
	// Clock
	always #2.5 mclk = ~mclk;
	motion_wake_ctrl #(.pulse_cycles(pw)) dut_u (.mclk(mclk), .srst(srst),
		.motion_wake_mode_setting(mode), .motion_wake_threshold_setting(thr),
		.cfg_load(cfg_load), .accel_x(ax), .accel_y(ay), .accel_z(az),
		.accel_valid(accel_valid), .sensor_irq(sensor_irq), .backup_mode(backup_mode),
		.external_irq_zero_wake_source(wake_src), .motion_wake_pin(pin),
		.rx_wake(rx_wake), .sensor_irq_out(irq_out), .active_threshold(act_thr));
	wake_pin_host host_u (.mclk(mclk), .srst(srst), .motion_wake_pin(pin),
		.pulse_count(n_pulse), .last_width(width));
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (exp !== got)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task apply(input logic [1:0] m, input logic [7:0] v);
		mode = m;
		thr = v;
		cfg_load = 1'b1;
		step(1);
		cfg_load = 1'b0;
		step(1);
	endtask
	task fire;
		n0 = n_pulse;
		sensor_irq = 1'b1;
		step(1);
		sensor_irq = 1'b0;
		step(12);
	endtask
	function logic [7:0] eff(input logic [7:0] v);
		return (v == 8'h00) ? 8'h80 : v;
	endfunction
	// Motion seen when the mode is on and any axis is above the threshold
	function logic hit_exp(input logic [1:0] m, input logic [7:0] v, input logic [7:0] x,
		input logic [7:0] y, input logic [7:0] z);
		return (m != 2'h0) && (x > eff(v) || y > eff(v) || z > eff(v));
	endfunction
	task finish_test;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		step(20);
		srst = 1'b0;
		step(1);
		chk("threshold", 8'h80, act_thr);
		chk("outputs", 8'h00, {6'h0, pin, rx_wake});
		$display("reset checks done");
		backup_mode = 1'b1;
		wake_src = 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			apply(m[1:0], 8'h00);
			step(4);
			fire;
			chk("pulses", {7'h0, m[1]}, n_pulse - n0);
			if (m[1])
				chk("width", pw[7:0], width);
			chk("rx_wake", {7'h0, m[0]}, {7'h0, rx_wake});
			step(30);
			chk("rx_wake held", {7'h0, m[0]}, {7'h0, rx_wake});
			backup_mode = 1'b0;
			step(5);
			chk("rx_wake off", 8'h00, {7'h0, rx_wake});
			backup_mode = 1'b1;
			step(4);
			$display("mode %0d done", m);
		end
		apply(2'h3, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			backup_mode = k[0];
			wake_src = ~k[0];
			step(4);
			fire;
			chk("rx_wake gated", 8'h00, {7'h0, rx_wake});
		end
		$display("wake gating done");
		for (int i = 0; i < 24; i++)
		begin
			t = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hff : 8'($random(seed));
			apply(i[1:0], t);
			chk("active threshold", eff(t), act_thr);
			ax = (i == 3) ? eff(t) : 8'($random(seed));
			ay = 8'($random(seed));
			az = 8'($random(seed));
			accel_valid = 1'b1;
			step(1);
			accel_valid = 1'b0;
			chk("motion", {7'h0, hit_exp(i[1:0], t, ax, ay, az)}, {7'h0, irq_out});
		end
		$display("threshold sweep done");
		finish_test;
	end
	// Watchdog
	initial
	begin
		#100000;
		num_errors++;
		finish_test;
	end
endmodule // motion_wake_ctrl_test
